/* File: rtl/pfs_pkg.sv */
// Constants, types and command codes for the power fault supervisor
// Function
// [RULE1] Any fault pulls shared line; low line stops switching
// [RULE2] Master locks rising sync edge, slave falling edge
// [RULE3] Host gives each module own address, reads separately
// [RULE4] Sample current mid low-side interval, average continually
// [RULE5] Negative current reads back as zero
// [RULE6] Average output voltage continually into readback
// [RULE7] Thermal fault halts conversion until 20C cooler
// [RULE8] Temperature readback at 8Dh always current
// [RULE9] Fault threshold at 4Fh, warning at 51h
// [RULE10] Thermal events set 7Dh flags, alert unless masked
// [RULE11] Above 145C set bandgap bit, halt, alert
// [RULE12] Thermal action latch, restart or ignore; restart default
// [RULE13] Bandgap trip always shuts down then restarts
// [RULE14] High-side short ends pulse in same cycle
// [RULE15] Compare averaged current with fault and warning limits
// [RULE16] Counter up per overcurrent cycle, down otherwise
// [RULE17] Count three declares fault; act per setting
// [RULE18] Overvoltage stops switching, low side on, flags, alert
// [RULE19] Overvoltage then hiccup or latch; ignore keeps regulating
// [RULE20] Overvoltage watch active once rail above lockout
// [RULE21] Undervoltage after soft-start: both off, flag, act
// [RULE22] Fixed feedback overvoltage threshold also applies
// [RULE23] Restart delay is seven soft-start rise times
// [RULE24] Flags stick until cleared; alert while unmasked flag
package pfs_pkg;
    localparam logic [7:0]         CMD_OT_FAULT      = 8'h4f;
    localparam logic [7:0]         CMD_OT_WARN       = 8'h51;
    localparam logic [7:0]         CMD_STATUS_TEMP   = 8'h7d;
    localparam logic [7:0]         CMD_VENDOR_STATUS = 8'h80;
    localparam logic [7:0]         CMD_OUTPUT_VOLTAGE_READBACK     = 8'h8b;
    localparam logic [7:0]         CMD_OUTPUT_CURRENT_READBACK     = 8'h8c;
    localparam logic [7:0]         CMD_READ_TEMP     = 8'h8d;
    localparam logic [7:0]         CMD_WINDOW        = 8'hd7;
    localparam int                 TEMP_OTF_BIT      = 7;
    localparam int                 TEMP_OTW_BIT      = 6;
    localparam int                 VEND_BG_BIT       = 0;
    localparam logic signed [15:0] BG_TRIP_C         = 16'sh0091;
    localparam logic signed [15:0] HYST_C            = 16'sh0014;
    localparam logic [1:0]         OC_TRIP_COUNT     = 2'h3;
    localparam int                 RISE_MULT         = 7;
    localparam logic [15:0]        OT_FAULT_RST      = 16'h007d;
    localparam logic [15:0]        OT_WARN_RST       = 16'h0064;
    localparam logic [7:0]         WINDOW_RST        = 8'h00;
    localparam int                 AVG_SHIFT         = 3;
    localparam int                 CLK_PERIOD_NS     = 4;
    localparam int                 NS_PER_MS         = 1000000;
    localparam int                 CYC_PER_MS        = NS_PER_MS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {ACT_IGNORE, ACT_LATCH, ACT_RESTART} pfs_action_t;
    typedef enum logic [1:0] {ST_RUN, ST_COOL, ST_HICCUP, ST_LATCH} pfs_fsm_t;

    typedef struct packed {
        logic sync_clk;
        logic share_low;
        logic role_slave;
        logic fdbk_ov;
        logic fdbk_fixed_ov;
        logic fdbk_uv;
        logic hs_short;
        logic rail_ok;
    } pfs_pins_t;

    typedef struct packed {
        logic ot_fault;
        logic ot_warn;
        logic bg_trip;
        logic oc_fault;
        logic oc_warn;
        logic ov_fault;
        logic uv_fault;
    } pfs_flags_t;

    typedef struct packed {
        pfs_action_t thermal;
        pfs_action_t oc;
        pfs_action_t ov;
        pfs_action_t uv;
    } pfs_actions_t;
endpackage : pfs_pkg

/* File: rtl/pfs_supervisor.sv */
// Fault supervision, telemetry and phase lock of one converter module
`timescale 1ns/1ps
`default_nettype none
module pfs_supervisor
    import pfs_pkg::*;
#(
    parameter int RESTART_CYC_PER_MS = CYC_PER_MS
) (
    input  wire logic         ref_clk_i,
    input  wire logic         srst_i,
    input  wire pfs_pins_t    pins_i,
    input  wire logic         pwm_i,
    input  wire logic         conv_enable_i,
    input  wire logic         soft_start_done_i,
    input  wire logic [15:0]  iout_sample_i,
    input  wire logic [15:0]  vout_sample_i,
    input  wire logic [15:0]  temp_sample_i,
    input  wire logic [7:0]   rise_ms_i,
    input  wire pfs_actions_t actions_i,
    input  wire logic [15:0]  oc_fault_limit_i,
    input  wire logic [15:0]  oc_warn_limit_i,
    input  wire pfs_flags_t   alert_mask_i,
    input  wire logic         clear_faults_i,
    input  wire logic [7:0]   cmd_i,
    input  wire logic         wr_i,
    input  wire logic [15:0]  wdata_i,
    input  wire logic         rd_i,
    output logic [15:0]       rdata_o,
    output logic              rvalid_o,
    output logic              hs_drive_o,
    output logic              ls_drive_o,
    output logic              share_line_o,
    output logic              share_line_oe_o,
    output pfs_flags_t        flags_o,
    output logic              alert_n_o,
    output logic [7:0]        window_limits_o
);
    typedef struct packed {
        pfs_pins_t   s1;
        pfs_pins_t   s2;
        logic        clk_prev;
        logic [15:0] iout_avg;
        logic [15:0] vout_avg;
        logic [15:0] temp_rd;
        logic [15:0] ot_flt_lim;
        logic [15:0] ot_wrn_lim;
        logic [7:0]  win_lim;
        logic [15:0] ls_cnt;
        logic [15:0] ls_len;
        logic [1:0]  oc_cnt;
        logic        oc_seen;
        logic        hs_term;
        pfs_flags_t  flags;
        pfs_fsm_t    fsm;
        logic [15:0] cool_lim;
        logic [31:0] wait_cnt;
        logic        hs;
        logic        ls;
        logic        share_pull;
        logic        alert_n;
        logic [15:0] rdata;
        logic        rvalid;
    } pfs_state_t;

    pfs_state_t         state_ff;
    pfs_state_t         nxt_state;
    pfs_pins_t          p;
    pfs_flags_t         set_f;
    pfs_flags_t         clr_f;
    logic               cyc_tick;
    logic signed [15:0] temp_s;
    logic               bg_now;
    logic               ot_now;
    logic               ot_warn_now;
    logic               ov_now;
    logic               ov_clamp;
    logic               uv_now;
    logic               oc_over;
    logic               oc_seen_now;
    logic               oc_evt;
    logic               run_ok;
    logic [31:0]        restart_target;
    logic [15:0]        iout_rb;

    // Shift-based running average; cheap, and each new sample weighs 1/2^AVG_SHIFT
    function automatic logic [15:0] pfs_avg(input logic [15:0] acc, input logic [15:0] smp);
        logic signed [16:0] d;
        d = $signed({smp[15], smp}) - $signed({acc[15], acc});
        d = d >>> AVG_SHIFT;
        return acc + d[15:0];
    endfunction : pfs_avg

    assign p        = state_ff.s2;
    // [RULE2] Phase edge select
    assign cyc_tick = p.role_slave ? (~p.sync_clk & state_ff.clk_prev) : (p.sync_clk & ~state_ff.clk_prev);
    assign temp_s   = $signed(temp_sample_i);
    // [RULE11] Fixed trip level
    assign bg_now      = temp_s > BG_TRIP_C;
    // [RULE7] Threshold compares
    assign ot_now      = temp_s >= $signed(state_ff.ot_flt_lim);
    assign ot_warn_now = temp_s >= $signed(state_ff.ot_wrn_lim);
    // [RULE20] Watch from rail lockout
    // [RULE22] Fixed threshold joins
    assign ov_now      = p.rail_ok & (p.fdbk_ov | p.fdbk_fixed_ov);
    // [RULE19] Ignore keeps regulating
    assign ov_clamp    = ov_now & (actions_i.ov != ACT_IGNORE);
    // [RULE21] Only after soft-start
    assign uv_now      = soft_start_done_i & p.fdbk_uv & (state_ff.fsm == ST_RUN);
    // [RULE15] Averaged current compare
    assign oc_over     = ($signed(state_ff.iout_avg) > $signed(oc_fault_limit_i)) | p.hs_short;
    assign oc_seen_now = state_ff.oc_seen | oc_over;
    // [RULE17] Third counted cycle trips
    assign oc_evt      = cyc_tick & oc_seen_now & (state_ff.oc_cnt >= OC_TRIP_COUNT - 2'h1);
    // [RULE23] Seven rise times
    assign restart_target = 32'(rise_ms_i) * 32'(RISE_MULT) * 32'(RESTART_CYC_PER_MS);
    // [RULE1] Stop when line pulled
    assign run_ok  = (state_ff.fsm == ST_RUN) & conv_enable_i & ~p.share_low & ~ov_clamp;
    // [RULE5] Sinking current reads zero
    assign iout_rb = state_ff.iout_avg[15] ? 16'h0000 : state_ff.iout_avg;

    always_comb begin
        nxt_state          = state_ff;
        nxt_state.s1       = pins_i;
        nxt_state.s2       = state_ff.s1;
        nxt_state.clk_prev = state_ff.s2.sync_clk;
        nxt_state.rvalid   = 1'b0;
        // [RULE8] Temperature always latest
        nxt_state.temp_rd  = temp_sample_i;
        // [RULE6] Voltage average
        nxt_state.vout_avg = pfs_avg(state_ff.vout_avg, vout_sample_i);

        // [RULE4] Midpoint of low-side interval
        if (state_ff.ls) begin
            nxt_state.ls_cnt = state_ff.ls_cnt + 16'h0001;
            if (state_ff.ls_cnt == {1'b0, state_ff.ls_len[15:1]}) begin
                nxt_state.iout_avg = pfs_avg(state_ff.iout_avg, iout_sample_i);
            end
        end else if (state_ff.ls_cnt != 16'h0000) begin
            nxt_state.ls_len = state_ff.ls_cnt;
            nxt_state.ls_cnt = 16'h0000;
        end

        // [RULE16] Per-cycle up/down count
        if (cyc_tick) begin
            nxt_state.oc_seen = 1'b0;
            nxt_state.hs_term = 1'b0;
            if (oc_seen_now) begin
                if (state_ff.oc_cnt != OC_TRIP_COUNT) begin
                    nxt_state.oc_cnt = state_ff.oc_cnt + 2'h1;
                end
            end else if (state_ff.oc_cnt != 2'h0) begin
                nxt_state.oc_cnt = state_ff.oc_cnt - 2'h1;
            end
        end else begin
            nxt_state.oc_seen = oc_seen_now;
            nxt_state.hs_term = state_ff.hs_term | p.hs_short;
        end

        set_f          = '0;
        set_f.ot_fault = ot_now;
        set_f.ot_warn  = ot_warn_now;
        set_f.bg_trip  = bg_now;
        set_f.oc_fault = oc_evt;
        set_f.oc_warn  = $signed(state_ff.iout_avg) > $signed(oc_warn_limit_i);
        set_f.ov_fault = ov_now;
        set_f.uv_fault = uv_now;
        clr_f          = clear_faults_i ? '1 : '0;

        if (wr_i) begin
            case (cmd_i)
                // [RULE9] Bus-written thresholds
                CMD_OT_FAULT: nxt_state.ot_flt_lim = wdata_i;
                CMD_OT_WARN: nxt_state.ot_wrn_lim = wdata_i;
                CMD_WINDOW: nxt_state.win_lim = wdata_i[7:0];
                CMD_STATUS_TEMP: begin
                    clr_f.ot_fault = clr_f.ot_fault | wdata_i[TEMP_OTF_BIT];
                    clr_f.ot_warn  = clr_f.ot_warn | wdata_i[TEMP_OTW_BIT];
                end
                default: ;
            endcase
        end
        // [RULE24] Sticky, set beats clear
        // [RULE10] Thermal event flags
        nxt_state.flags = pfs_flags_t'(({state_ff.flags} & ~{clr_f}) | {set_f});

        if (rd_i) begin
            nxt_state.rvalid = 1'b1;
            case (cmd_i)
                CMD_OT_FAULT: nxt_state.rdata = state_ff.ot_flt_lim;
                CMD_OT_WARN: nxt_state.rdata = state_ff.ot_wrn_lim;
                CMD_WINDOW: nxt_state.rdata = {8'h00, state_ff.win_lim};
                CMD_STATUS_TEMP: nxt_state.rdata = {8'h00, state_ff.flags.ot_fault, state_ff.flags.ot_warn, 6'h00};
                CMD_VENDOR_STATUS: nxt_state.rdata = {15'h0000, state_ff.flags.bg_trip};
                CMD_READ_TEMP: nxt_state.rdata = state_ff.temp_rd;
                CMD_OUTPUT_VOLTAGE_READBACK: nxt_state.rdata = state_ff.vout_avg;
                CMD_OUTPUT_CURRENT_READBACK: nxt_state.rdata = iout_rb;
                default: nxt_state.rdata = 16'h0000;
            endcase
        end

        case (state_ff.fsm)
            ST_RUN: begin
                // [RULE13] Bandgap never ignored
                if (bg_now) begin
                    nxt_state.fsm      = ST_COOL;
                    nxt_state.cool_lim = 16'(BG_TRIP_C - HYST_C);
                // [RULE12] Selectable thermal action
                end else if (ot_now && actions_i.thermal != ACT_IGNORE) begin
                    nxt_state.fsm      = (actions_i.thermal == ACT_LATCH) ? ST_LATCH : ST_COOL;
                    nxt_state.cool_lim = 16'($signed(state_ff.ot_flt_lim) - HYST_C);
                // [RULE18] Overvoltage shutdown
                end else if (ov_clamp) begin
                    nxt_state.fsm = (actions_i.ov == ACT_LATCH) ? ST_LATCH : ST_HICCUP;
                end else if (oc_evt && actions_i.oc != ACT_IGNORE) begin
                    nxt_state.fsm = (actions_i.oc == ACT_LATCH) ? ST_LATCH : ST_HICCUP;
                end else if (uv_now && actions_i.uv != ACT_IGNORE) begin
                    nxt_state.fsm = (actions_i.uv == ACT_LATCH) ? ST_LATCH : ST_HICCUP;
                end
                nxt_state.wait_cnt = 32'h0000_0000;
            end
            ST_COOL: begin
                if (bg_now) begin
                    nxt_state.cool_lim = 16'(BG_TRIP_C - HYST_C);
                end else if (temp_s <= $signed(state_ff.cool_lim)) begin
                    nxt_state.fsm = ST_RUN;
                end
            end
            ST_HICCUP: begin
                nxt_state.wait_cnt = state_ff.wait_cnt + 32'h0000_0001;
                if (bg_now) begin
                    nxt_state.fsm      = ST_COOL;
                    nxt_state.cool_lim = 16'(BG_TRIP_C - HYST_C);
                end else if (state_ff.wait_cnt >= restart_target) begin
                    nxt_state.fsm    = ST_RUN;
                    nxt_state.oc_cnt = 2'h0;
                end
            end
            ST_LATCH: begin
                if (!conv_enable_i) begin
                    nxt_state.fsm    = ST_RUN;
                    nxt_state.oc_cnt = 2'h0;
                end
            end
            default: nxt_state.fsm = ST_RUN;
        endcase

        // [RULE14] Short ends high-side pulse
        nxt_state.hs         = run_ok & pwm_i & ~state_ff.hs_term & ~p.hs_short;
        nxt_state.ls         = ov_clamp | (run_ok & ~pwm_i);
        // [RULE1] Pull shared line on fault
        nxt_state.share_pull = (nxt_state.fsm != ST_RUN) | ov_clamp;
        nxt_state.alert_n    = ~|({nxt_state.flags} & ~{alert_mask_i});
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            state_ff            <= '0;
            state_ff.ot_flt_lim <= OT_FAULT_RST;
            state_ff.ot_wrn_lim <= OT_WARN_RST;
            state_ff.win_lim    <= WINDOW_RST;
            state_ff.alert_n    <= 1'b1;
            state_ff.fsm        <= ST_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign rdata_o         = state_ff.rdata;
    assign rvalid_o        = state_ff.rvalid;
    assign hs_drive_o      = state_ff.hs;
    assign ls_drive_o      = state_ff.ls;
    assign share_line_o    = 1'b0;
    assign share_line_oe_o = state_ff.share_pull;
    assign flags_o         = state_ff.flags;
    assign alert_n_o       = state_ff.alert_n;
    assign window_limits_o = state_ff.win_lim;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);

    share_stop_a: assert property (p.share_low |=> !hs_drive_o) // [RULE1]
        else $error("switching continued with shared line low");
    phase_lock_a: assert property (cyc_tick |-> (p.sync_clk != p.role_slave)) // [RULE2]
        else $error("cycle tick on wrong sync edge");
    iout_clamp_a: assert property (rd_i && cmd_i == CMD_OUTPUT_CURRENT_READBACK |=> !rdata_o[15]) // [RULE5]
        else $error("negative current read back");
    bg_shutdown_a: assert property (bg_now |=> flags_o.bg_trip ##1 (!hs_drive_o && !ls_drive_o) || ov_clamp) // [RULE11]
        else $error("bandgap trip did not shut down");
    short_term_a: assert property (p.hs_short |=> !hs_drive_o ##1 !hs_drive_o || $past(cyc_tick, 2)) // [RULE14]
        else $error("high-side pulse not ended on short");
    oc_trip_a: assert property (oc_evt && state_ff.fsm == ST_RUN && !bg_now && !ot_now && !ov_now
                                && actions_i.oc == ACT_LATCH |=> state_ff.fsm == ST_LATCH && flags_o.oc_fault) // [RULE17]
        else $error("overcurrent count three did not latch");
    ov_clamp_a: assert property (ov_clamp |=> ls_drive_o && !hs_drive_o) // [RULE18]
        else $error("overvoltage did not clamp low side");
    uv_gate_a: assert property ($rose(flags_o.uv_fault) |-> $past(soft_start_done_i)) // [RULE21]
        else $error("undervoltage flagged before soft-start done");
    hiccup_wait_a: assert property (state_ff.fsm == ST_HICCUP && state_ff.wait_cnt < restart_target && !bg_now
                                    |=> state_ff.fsm == ST_HICCUP) // [RULE23]
        else $error("hiccup restart came early");
    flag_hold_a: assert property (flags_o.ot_warn && !clear_faults_i && !(wr_i && cmd_i == CMD_STATUS_TEMP)
                                  |=> flags_o.ot_warn) // [RULE24]
        else $error("warning flag dropped without clear");
    alert_a: assert property ((|({flags_o} & ~{alert_mask_i})) && $stable(alert_mask_i) |-> !alert_n_o) // [RULE10]
        else $error("alert not asserted for unmasked flag");

    hiccup_cov: cover property (state_ff.fsm == ST_HICCUP ##1 state_ff.fsm == ST_RUN);
    cool_cov: cover property (state_ff.fsm == ST_COOL ##1 state_ff.fsm == ST_RUN);
    latch_cov: cover property (state_ff.fsm == ST_LATCH && !conv_enable_i);
endmodule : pfs_supervisor
`default_nettype wire

/* File: verif/pfs_far_end.sv */
// Far side model: shared sync clock and a paralleled slave on the fault line
`timescale 1ns/1ps
`default_nettype none
module pfs_far_end (
    input  wire logic dut_pull_i,
    input  wire logic slave_fault_i,
    output logic      sync_clk_o,
    output logic      line_low_o
);
    initial begin
        sync_clk_o = 1'b0;
        forever #80 sync_clk_o = ~sync_clk_o;
    end
    // Wired line, low if either side pulls
    assign line_low_o = dut_pull_i | slave_fault_i;
endmodule : pfs_far_end
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench for the power fault supervisor
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pfs_pkg::*;
    logic         ref_clk_i, srst_i, pwm, en, ss_done, wr, rd, clr;
    logic         ov, fov, uv, hs_short, rail_ok, slave_flt, sync_clk, line_low, role;
    logic         rvalid, hs, ls, sh_o, sh_oe, alert_n;
    logic [7:0]   cmd, rise_ms, win;
    logic [15:0]  wdata, iout, vout, temp, rdata, d;
    pfs_actions_t acts;
    pfs_flags_t   mask, flags;
    pfs_pins_t    pins;
    int           errors, tests_run, pc, n;

    assign pins = {sync_clk, line_low, role, ov, fov, uv, hs_short, rail_ok};

    pfs_far_end far_u (.dut_pull_i(sh_oe), .slave_fault_i(slave_flt), .sync_clk_o(sync_clk),
                       .line_low_o(line_low));
    pfs_supervisor #(.RESTART_CYC_PER_MS(4)) dut_u (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .pins_i(pins), .pwm_i(pwm), .conv_enable_i(en),
        .soft_start_done_i(ss_done), .iout_sample_i(iout), .vout_sample_i(vout),
        .temp_sample_i(temp), .rise_ms_i(rise_ms), .actions_i(acts),
        .oc_fault_limit_i(16'h7fff), .oc_warn_limit_i(16'h0064), .alert_mask_i(mask),
        .clear_faults_i(clr), .cmd_i(cmd), .wr_i(wr), .wdata_i(wdata), .rd_i(rd),
        .rdata_o(rdata), .rvalid_o(rvalid), .hs_drive_o(hs), .ls_drive_o(ls),
        .share_line_o(sh_o), .share_line_oe_o(sh_oe), .flags_o(flags), .alert_n_o(alert_n),
        .window_limits_o(win));

    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    // PWM of 10 high, 30 low cycles gives low-side intervals to sample
    always @(negedge ref_clk_i) begin
        pc <= (pc == 39) ? 0 : pc + 1;
        pwm <= (pc < 10);
    end

    task automatic close_out;
        if (errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic chk1(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask : chk1
    task automatic chk_in(input string what, input logic [15:0] lo, hi, got);
        tests_run++;
        if (((got >= lo) && (got <= hi)) !== 1'b1) begin
            errors++;
            $display("CHECK FAILED %s expected %h..%h seen %h", what, lo, hi, got);
        end
    endtask : chk_in
    task automatic cyc(input int k);
        repeat (k) @(negedge ref_clk_i);
    endtask : cyc
    task automatic wr_reg(input logic [7:0] c, input logic [15:0] v);
        @(negedge ref_clk_i);
        cmd = c;
        wdata = v;
        wr = 1'b1;
        @(negedge ref_clk_i);
        wr = 1'b0;
    endtask : wr_reg
    // Host reaches this module alone; a second module would sit at its own address
    task automatic rd_reg(input logic [7:0] c, output logic [15:0] v);
        int i;
        @(negedge ref_clk_i);
        cmd = c;
        rd = 1'b1;
        @(negedge ref_clk_i);
        rd = 1'b0;
        for (i = 0; i < 4 && rvalid !== 1'b1; i++) @(negedge ref_clk_i);
        if (rvalid !== 1'b1) begin
            errors++;
            close_out();
        end
        v = rdata;
    endtask : rd_reg
    task automatic wait_oe(input logic v, input int lim, output int k);
        for (k = 0; k < lim && sh_oe !== v; k++) @(negedge ref_clk_i);
        if (sh_oe !== v) begin
            errors++;
            close_out();
        end
    endtask : wait_oe
    // High-side activity over one switching period
    task automatic act(output int k);
        k = 0;
        repeat (40) begin
            @(negedge ref_clk_i);
            k += (hs === 1'b1);
        end
    endtask : act
    task automatic clear;
        @(negedge ref_clk_i);
        clr = 1'b1;
        @(negedge ref_clk_i);
        clr = 1'b0;
    endtask : clear
    task automatic release_latch;
        en = 1'b0;
        cyc(2);
        en = 1'b1;
        wait_oe(1'b0, 20, n);
    endtask : release_latch

    task automatic t_regs;
        rd_reg(CMD_OT_FAULT, d); chk("fault limit", 16'h007d, d);
        rd_reg(CMD_OT_WARN, d); chk("warn limit", 16'h0064, d);
        rd_reg(CMD_WINDOW, d); chk("window", 16'h0000, d);
        wr_reg(8'h99, 16'h1234);
        rd_reg(8'h99, d); chk("unmapped", 16'h0000, d);
        wr_reg(CMD_OT_FAULT, 16'h0082);
        rd_reg(CMD_OT_FAULT, d); chk("fault limit wr", 16'h0082, d);
        wr_reg(CMD_OT_FAULT, 16'h007d);
        wr_reg(CMD_WINDOW, 16'h005a);
        rd_reg(CMD_WINDOW, d); chk("window wr", 16'h005a, d);
        chk("window out", 16'h005a, {8'h00, win});
    endtask : t_regs
    task automatic t_telem;
        temp = 16'h002a;
        vout = 16'h0200;
        iout = 16'h01f4;
        rd_reg(CMD_READ_TEMP, d); chk("temp", 16'h002a, d);
        cyc(1000);
        rd_reg(CMD_OUTPUT_VOLTAGE_READBACK, d); chk_in("vout", 16'h01f0, 16'h0200, d);
        rd_reg(CMD_OUTPUT_CURRENT_READBACK, d); chk_in("iout", 16'h01b0, 16'h01f4, d);
        chk1("oc warn", 1'b1, flags.oc_warn);
        iout = 16'hff38;
        cyc(1200);
        rd_reg(CMD_OUTPUT_CURRENT_READBACK, d); chk("iout neg", 16'h0000, d);
        clear();
    endtask : t_telem
    task automatic t_thermal;
        mask.ot_warn = 1'b1;
        temp = 16'h006e;
        cyc(4);
        chk1("warn flag", 1'b1, flags.ot_warn);
        chk1("masked alert", 1'b1, alert_n);
        mask.ot_warn = 1'b0;
        cyc(2);
        chk1("alert", 1'b0, alert_n);
        temp = 16'h0082;
        cyc(4);
        chk1("ot flag", 1'b1, flags.ot_fault);
        chk1("ot pull", 1'b1, sh_oe);
        rd_reg(CMD_STATUS_TEMP, d); chk("temp status", 16'h00c0, d & 16'h00c0);
        act(n); chk1("ot halted", 1'b0, n > 0);
        temp = 16'h0070;
        cyc(8);
        chk1("ot hyst", 1'b1, sh_oe);
        temp = 16'h0064;
        wait_oe(1'b0, 20, n);
        act(n); chk1("ot restart", 1'b1, n > 0);
        chk1("sticky", 1'b1, flags.ot_fault);
        temp = 16'h002a;
        wr_reg(CMD_STATUS_TEMP, 16'h00c0);
        rd_reg(CMD_STATUS_TEMP, d); chk("status clr", 16'h0000, d & 16'h00c0);
        chk1("alert off", 1'b1, alert_n);
    endtask : t_thermal
    task automatic t_bandgap;
        acts.thermal = ACT_IGNORE;
        temp = 16'h0096;
        cyc(4);
        chk1("bg flag", 1'b1, flags.bg_trip);
        rd_reg(CMD_VENDOR_STATUS, d); chk("vendor", 16'h0001, d & 16'h0001);
        chk1("bg halt", 1'b1, sh_oe);
        temp = 16'h0082;
        cyc(8);
        chk1("bg hyst", 1'b1, sh_oe);
        temp = 16'h0078;
        wait_oe(1'b0, 20, n);
        temp = 16'h002a;
        acts.thermal = ACT_RESTART;
        clear();
    endtask : t_bandgap
    task automatic t_oc;
        rise_ms = 8'h01;
        hs_short = 1'b1;
        // Two cycles of pin sync plus the drive register pass before the cut shows
        cyc(2);
        n = 0;
        repeat (38) begin
            @(negedge ref_clk_i);
            n += (hs === 1'b1);
        end
        chk1("short cut", 1'b0, n > 0);
        hs_short = 1'b0;
        cyc(200);
        hs_short = 1'b1;
        cyc(60);
        chk1("oc count down", 1'b0, flags.oc_fault);
        for (n = 0; n < 400 && flags.oc_fault !== 1'b1; n++) @(negedge ref_clk_i);
        chk1("oc fault", 1'b1, flags.oc_fault);
        hs_short = 1'b0;
        wait_oe(1'b0, 100, n);
        chk_in("hiccup", 16'd27, 16'd31, 16'(n));
        clear();
    endtask : t_oc
    task automatic t_ov;
        acts.ov = ACT_LATCH;
        rail_ok = 1'b0;
        ov = 1'b1;
        act(n); chk1("ov before rail", 1'b1, n > 0);
        rail_ok = 1'b1;
        cyc(4);
        chk1("ov ls", 1'b1, ls);
        chk1("ov hs", 1'b0, hs);
        chk1("ov flag", 1'b1, flags.ov_fault);
        chk1("ov alert", 1'b0, alert_n);
        ov = 1'b0;
        cyc(4);
        chk1("ov latched", 1'b1, sh_oe);
        release_latch();
        clear();
        acts.ov = ACT_IGNORE;
        fov = 1'b1;
        act(n); chk1("ov ignore", 1'b1, n > 0);
        chk1("fixed ov flag", 1'b1, flags.ov_fault);
        fov = 1'b0;
        cyc(4);
        acts.ov = ACT_RESTART;
        clear();
    endtask : t_ov
    task automatic t_uv;
        acts.uv = ACT_LATCH;
        ss_done = 1'b0;
        uv = 1'b1;
        cyc(6);
        chk1("uv soft start", 1'b0, flags.uv_fault);
        ss_done = 1'b1;
        cyc(6);
        chk1("uv flag", 1'b1, flags.uv_fault);
        act(n); chk1("uv off", 1'b0, n > 0);
        uv = 1'b0;
        cyc(4);
        release_latch();
        clear();
    endtask : t_uv
    task automatic t_slave;
        slave_flt = 1'b1;
        cyc(4);
        act(n); chk1("slave stop", 1'b0, n > 0);
        slave_flt = 1'b0;
        cyc(4);
        act(n); chk1("slave resume", 1'b1, n > 0);
        chk1("line level", 1'b0, sh_o);
        role = 1'b1;
        cyc(4);
        act(n); chk1("slave phase run", 1'b1, n > 0);
        role = 1'b0;
    endtask : t_slave

    initial begin
        {srst_i, pc, pwm, en, ss_done, wr, rd, clr, errors, tests_run} = '0;
        {ov, fov, uv, hs_short, slave_flt, role, cmd, wdata, iout, vout, mask} = '0;
        srst_i = 1'b1;
        en = 1'b1;
        ss_done = 1'b1;
        rail_ok = 1'b1;
        temp = 16'h002a;
        rise_ms = 8'h01;
        acts = '{ACT_RESTART, ACT_RESTART, ACT_RESTART, ACT_RESTART};
        cyc(4);
        srst_i = 1'b0;
        cyc(4);
        t_regs();
        t_telem();
        t_thermal();
        t_bandgap();
        t_oc();
        t_ov();
        t_uv();
        t_slave();
        close_out();
    end
endmodule : testbench
`default_nettype wire
